// File: src/light_regs_pkg.sv
package light_regs_pkg;
	localparam logic [7:0] OFS_WAIT_EXT_CFG = 8'h0D;
	localparam logic [7:0] OFS_GAIN_CTRL = 8'h0F;
	localparam logic [7:0] OFS_PART_ID = 8'h12;
	localparam logic [7:0] OFS_FLAGS = 8'h13;
	localparam logic [7:0] OFS_VIS_LOW = 8'h14;
	localparam logic [7:0] OFS_VIS_HIGH = 8'h15;
	localparam logic [7:0] OFS_IR_LOW = 8'h16;
	localparam logic [7:0] OFS_IR_HIGH = 8'h17;
	localparam int WAIT_EXT_BIT_POS = 1;
	localparam int IRQ_FLAG_POS = 4;
	localparam int DONE_FLAG_POS = 0;
	localparam logic [7:0] CFG_RESET = 8'h00;
	localparam logic [7:0] CTRL_RESET = 8'h00;
	localparam logic [1:0] GAIN_FIELD_MASK = 2'h3;
	localparam logic [7:0] WAIT_EXT_FACTOR = 8'h0C;
	localparam int WAIT_STEP_US = 2720;
	localparam int CLK_MHZ = 50;
	localparam int WAIT_STEP_CYCLES = WAIT_STEP_US * CLK_MHZ;
	localparam int RESULT_WIDTH = 16;
	localparam int NUM_CHANNELS = 2;
endpackage

// File: src/result_shadow.sv
`timescale 1ns/100ps
module result_shadow
	import light_regs_pkg::*;
#(
	parameter int WIDTH = RESULT_WIDTH
) (
	input wire logic core_clk,
	input wire logic rstn,
	input wire logic [WIDTH-1:0] result,
	input wire logic capture,
	output logic [WIDTH/2-1:0] shadow
);
	logic [WIDTH/2-1:0] next_shadow;

	initial begin
		if (WIDTH % 2 != 0)
			$error("result width must be even");
	end

	// latch upper half on low byte read
	always_comb begin
		next_shadow = shadow;
		if (capture)
			next_shadow = result[WIDTH-1:WIDTH/2];
	end

	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn)
			shadow <= '0;
		else
			shadow <= next_shadow;
	end

	a_shadow_holds: assert property (@(posedge core_clk) disable iff (!rstn)
		!capture |=> shadow == $past(shadow))
		else $error("shadow changed without low byte read");
	a_shadow_loads: assert property (@(posedge core_clk) disable iff (!rstn)
		capture |=> shadow == $past(result[WIDTH-1:WIDTH/2]))
		else $error("shadow did not load upper half");
endmodule

// File: src/light_regs.sv
// Overview of operation
// - wait extension bit stretches wait twelvefold
// - gain field selects 1x 8x 16x 120x
// - fixed part code, writes ignored
// - status register read only
// - status bit 4 mirrors interrupt output
// - status bit 0 set after both channels finish
// - results split low/high at 0x14-0x17
// - low byte read latches high shadow
// - shadow stays coherent across new results
// - interrupt on threshold cross (every conversion at persistence 0), masked, filtered
// - base wait in 2.72 ms two's complement steps
`timescale 1ns/100ps
module light_regs
	import light_regs_pkg::*;
#(
	parameter logic [7:0] PART_CODE = 8'hA5, // part code value is arbitrary
	parameter int WAIT_STEP = WAIT_STEP_CYCLES
) (
	input wire logic core_clk,
	input wire logic rstn,
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [7:0] reg_rdata,
	input wire logic [RESULT_WIDTH-1:0] visible_channel,
	input wire logic [RESULT_WIDTH-1:0] infrared_channel,
	input wire logic conversion_done,
	input wire logic clear_done,
	input wire logic [15:0] low_threshold,
	input wire logic [15:0] high_threshold,
	input wire logic irq_enable,
	input wire logic [3:0] persistence,
	input wire logic clear_irq,
	input wire logic wait_start,
	input wire logic [7:0] wait_period_field,
	output logic wait_busy,
	output logic [1:0] gain_select_field,
	output logic light_irq_out
);
	logic [7:0] wait_ext_cfg;
	logic [7:0] gain_ctrl;
	logic conversion_done_flag;
	logic light_irq_flag;
	logic [5:0] out_count;
	logic [RESULT_WIDTH-1:0] vis_result;
	logic [RESULT_WIDTH-1:0] ir_result;
	logic [31:0] wait_count;
	logic [7:0] next_rdata;
	logic [7:0] next_cfg;
	logic [7:0] next_ctrl;
	logic next_done;
	logic next_irq;
	logic [5:0] next_out_count;
	logic [RESULT_WIDTH-1:0] next_vis;
	logic [RESULT_WIDTH-1:0] next_ir;
	logic [31:0] next_wait_count;
	logic [NUM_CHANNELS-1:0] capture;
	logic [7:0] shadow [NUM_CHANNELS];
	logic [RESULT_WIDTH-1:0] results [NUM_CHANNELS];
	logic wait_extension_bit;
	logic out_of_range;
	logic [5:0] pers_needed;
	logic [31:0] wait_total;

	initial begin
		if (WAIT_STEP < 1)
			$error("wait step must be at least one cycle");
	end

	assign wait_extension_bit = wait_ext_cfg[WAIT_EXT_BIT_POS];
	assign gain_select_field = gain_ctrl[1:0] & GAIN_FIELD_MASK;
	assign light_irq_out = light_irq_flag;
	assign results[0] = vis_result;
	assign results[1] = ir_result;
	assign capture[0] = reg_rd && reg_addr == OFS_VIS_LOW;
	assign capture[1] = reg_rd && reg_addr == OFS_IR_LOW;

	// one shadow latch per channel
	genvar ch;
	generate
		for (ch = 0; ch < NUM_CHANNELS; ch++) begin : g_shadow
			result_shadow #(.WIDTH(RESULT_WIDTH)) u_shadow (
				.core_clk(core_clk),
				.rstn(rstn),
				.result(results[ch]),
				.capture(capture[ch]),
				.shadow(shadow[ch])
			);
		end
	endgenerate

	// wait length: (256 - field) steps, twelvefold when extended
	always_comb begin
		wait_total = 32'(9'h100 - {1'b0, wait_period_field}) * 32'(WAIT_STEP);
		if (wait_extension_bit)
			wait_total = wait_total * 32'(WAIT_EXT_FACTOR);
	end

	// persistence count table
	always_comb begin
		unique case (persistence)
			4'h0, 4'h1: pers_needed = 6'h01;
			4'h2: pers_needed = 6'h02;
			4'h3: pers_needed = 6'h03;
			default: pers_needed = 6'((int'(persistence) - 3) * 5);
		endcase
	end

	assign out_of_range = visible_channel < low_threshold || visible_channel > high_threshold;

	always_comb begin
		next_cfg = wait_ext_cfg;
		next_ctrl = gain_ctrl;
		if (reg_wr && reg_addr == OFS_WAIT_EXT_CFG)
			next_cfg = reg_wdata;
		if (reg_wr && reg_addr == OFS_GAIN_CTRL)
			next_ctrl = reg_wdata;
		// part code and flags ignore writes
	end

	// results, flags and persistence filter
	always_comb begin
		next_vis = vis_result;
		next_ir = ir_result;
		next_done = conversion_done_flag;
		next_irq = light_irq_flag;
		next_out_count = out_count;
		if (clear_done)
			next_done = 1'b0;
		if (clear_irq)
			next_irq = 1'b0;
		if (conversion_done) begin
			next_vis = visible_channel;
			next_ir = infrared_channel;
			next_done = 1'b1;
			if (persistence == 4'h0 || out_of_range) begin
				if (out_count < pers_needed)
					next_out_count = out_count + 6'h01;
				if (irq_enable && (persistence == 4'h0 || out_count + 6'h01 >= pers_needed))
					next_irq = 1'b1;
			end else begin
				next_out_count = 6'h00;
			end
		end
	end

	always_comb begin
		next_wait_count = wait_count;
		if (wait_start)
			next_wait_count = wait_total;
		else if (wait_count != 32'h0)
			next_wait_count = wait_count - 32'h1;
	end

	always_comb begin
		unique case (reg_addr)
			OFS_WAIT_EXT_CFG: next_rdata = wait_ext_cfg;
			OFS_GAIN_CTRL: next_rdata = gain_ctrl;
			OFS_PART_ID: next_rdata = PART_CODE;
			OFS_FLAGS: next_rdata = {3'h0, light_irq_flag, 3'h0, conversion_done_flag};
			OFS_VIS_LOW: next_rdata = vis_result[7:0];
			OFS_VIS_HIGH: next_rdata = shadow[0];
			OFS_IR_LOW: next_rdata = ir_result[7:0];
			OFS_IR_HIGH: next_rdata = shadow[1];
			default: next_rdata = 8'h00;
		endcase
	end

	assign wait_busy = wait_count != 32'h0;

	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			wait_ext_cfg <= CFG_RESET;
			gain_ctrl <= CTRL_RESET;
			conversion_done_flag <= 1'b0;
			light_irq_flag <= 1'b0;
			out_count <= 6'h00;
			vis_result <= '0;
			ir_result <= '0;
			wait_count <= 32'h0;
			reg_rdata <= 8'h00;
		end else begin
			wait_ext_cfg <= next_cfg;
			gain_ctrl <= next_ctrl;
			conversion_done_flag <= next_done;
			light_irq_flag <= next_irq;
			out_count <= next_out_count;
			vis_result <= next_vis;
			ir_result <= next_ir;
			wait_count <= next_wait_count;
			reg_rdata <= next_rdata;
		end
	end

	a_id_readback: assert property (@(posedge core_clk) disable iff (!rstn)
		reg_rd && reg_addr == OFS_PART_ID |=> reg_rdata == PART_CODE)
		else $error("part code read wrong");
	a_flags_irq_bit: assert property (@(posedge core_clk) disable iff (!rstn)
		reg_rd && reg_addr == OFS_FLAGS |=> reg_rdata[IRQ_FLAG_POS] == $past(light_irq_out))
		else $error("status bit 4 not tracking interrupt");
	a_done_sets: assert property (@(posedge core_clk) disable iff (!rstn)
		conversion_done |=> conversion_done_flag)
		else $error("done flag not set");
	a_flags_no_write: assert property (@(posedge core_clk) disable iff (!rstn)
		reg_wr && reg_addr == OFS_FLAGS && !conversion_done && !clear_done
		|=> conversion_done_flag == $past(conversion_done_flag))
		else $error("status changed by write");
	a_gain_follows: assert property (@(posedge core_clk) disable iff (!rstn)
		reg_wr && reg_addr == OFS_GAIN_CTRL |=> gain_select_field == $past(reg_wdata[1:0]))
		else $error("gain not applied");
	a_wait_extended: assert property (@(posedge core_clk) disable iff (!rstn)
		wait_start |=> wait_count == 32'(256 - int'($past(wait_period_field))) * 32'(WAIT_STEP)
			* ($past(wait_extension_bit) ? 32'h0000000C : 32'h00000001))
		else $error("wait length wrong");
	a_high_coherent: assert property (@(posedge core_clk) disable iff (!rstn)
		reg_rd && reg_addr == OFS_VIS_LOW ##1 reg_rd && reg_addr == OFS_VIS_HIGH
		|=> reg_rdata == $past(vis_result[15:8], 2))
		else $error("high byte incoherent");
	a_low_byte: assert property (@(posedge core_clk) disable iff (!rstn)
		reg_rd && reg_addr == OFS_IR_LOW |=> reg_rdata == $past(ir_result[7:0]))
		else $error("low byte wrong");
	a_irq_masked: assert property (@(posedge core_clk) disable iff (!rstn)
		!light_irq_flag && !irq_enable |=> !light_irq_flag)
		else $error("interrupt raised while masked");
	c_pair_read: cover property (@(posedge core_clk)
		reg_rd && reg_addr == OFS_VIS_LOW ##1 reg_rd && reg_addr == OFS_VIS_HIGH);
	c_irq_raised: cover property (@(posedge core_clk) $rose(light_irq_flag));
	c_long_wait: cover property (@(posedge core_clk) wait_start && wait_extension_bit);
	c_update_between: cover property (@(posedge core_clk)
		capture[0] ##2 conversion_done ##2 reg_rd && reg_addr == OFS_VIS_HIGH);
endmodule

// File: dv/host_model.sv
`timescale 1ns/100ps
module host_model (
	input wire logic core_clk,
	output logic [7:0] reg_addr,
	output logic [7:0] reg_wdata,
	output logic reg_wr,
	output logic reg_rd,
	input wire logic [7:0] reg_rdata
);
	initial begin
		reg_addr = 8'h00;
		reg_wdata = 8'h00;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
	end
	// caller passes reserved config bits as zero
	task automatic write_reg(input logic [7:0] a, input logic [7:0] d);
		@(negedge core_clk);
		reg_addr = a;
		reg_wdata = d;
		reg_wr = 1'b1;
		@(negedge core_clk);
		reg_wr = 1'b0;
		reg_wdata = ~d;
	endtask
	task automatic read_reg(input logic [7:0] a, output logic [7:0] d);
		@(negedge core_clk);
		reg_addr = a;
		reg_rd = 1'b1;
		@(negedge core_clk);
		reg_rd = 1'b0;
		d = reg_rdata;
	endtask
	// low then high byte back to back
	task automatic read_pair(input logic [7:0] a, output logic [15:0] d);
		@(negedge core_clk);
		reg_addr = a;
		reg_rd = 1'b1;
		@(negedge core_clk);
		d[7:0] = reg_rdata;
		reg_addr = a + 8'h01;
		@(negedge core_clk);
		reg_rd = 1'b0;
		d[15:8] = reg_rdata;
	endtask
endmodule

// File: dv/test_light_regs.sv
`timescale 1ns/100ps
module test_light_regs
	import light_regs_pkg::*;
;
	// arbitrary part code
	localparam logic [7:0] CODE = 8'h5A;
	typedef struct packed {logic [7:0] a; logic [7:0] w; logic [7:0] e;} row_t;
	logic core_clk = 1'b0;
	logic rstn, reg_wr, reg_rd, conversion_done, clear_done, irq_enable, clear_irq;
	logic wait_start, wait_busy, light_irq_out;
	logic [7:0] reg_addr, reg_wdata, reg_rdata, wait_period_field;
	logic [15:0] visible_channel, infrared_channel, low_threshold, high_threshold, pd;
	logic [3:0] persistence;
	logic [1:0] gain_select_field;
	int error_cnt = 0;
	int total_checks = 0;
	row_t rows[9] = '{'{OFS_WAIT_EXT_CFG, 8'h02, 8'h02}, '{OFS_WAIT_EXT_CFG, 8'h00, 8'h00},
		'{OFS_GAIN_CTRL, 8'h00, 8'h00}, '{OFS_GAIN_CTRL, 8'h01, 8'h01},
		'{OFS_GAIN_CTRL, 8'h02, 8'h02}, '{OFS_GAIN_CTRL, 8'h03, 8'h03},
		'{OFS_PART_ID, 8'hFF, CODE}, '{OFS_FLAGS, 8'hFF, 8'h00}, '{8'h30, 8'h55, 8'h00}};
	always #10 core_clk = ~core_clk;
	host_model i_host_model (.core_clk(core_clk), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata));
	light_regs #(.PART_CODE(CODE), .WAIT_STEP(4)) i_light_regs (.core_clk(core_clk),
		.rstn(rstn), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
		.reg_rd(reg_rd), .reg_rdata(reg_rdata), .visible_channel(visible_channel),
		.infrared_channel(infrared_channel), .conversion_done(conversion_done),
		.clear_done(clear_done), .low_threshold(low_threshold),
		.high_threshold(high_threshold), .irq_enable(irq_enable), .persistence(persistence),
		.clear_irq(clear_irq), .wait_start(wait_start), .wait_period_field(wait_period_field),
		.wait_busy(wait_busy), .gain_select_field(gain_select_field),
		.light_irq_out(light_irq_out));
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		total_checks++;
		if (seen !== exp) begin
			error_cnt++;
			$display("mismatch at %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
		logic [7:0] d;
		i_host_model.read_reg(a, d);
		check(d, e);
	endtask
	task automatic pulse(ref logic s);
		@(negedge core_clk);
		s = 1'b1;
		@(negedge core_clk);
		s = 1'b0;
	endtask
	task automatic conv(input logic [15:0] v, input logic [15:0] r);
		visible_channel = v;
		infrared_channel = r;
		pulse(conversion_done);
	endtask
	task automatic wait_len(input logic [7:0] cfg, input logic [7:0] f);
		int n;
		i_host_model.write_reg(OFS_WAIT_EXT_CFG, cfg);
		wait_period_field = f;
		n = 0;
		pulse(wait_start);
		while (wait_busy === 1'b1 && n < 300) begin
			n++;
			@(negedge core_clk);
		end
		check(16'(n), 16'((256 - f) * 4 * (cfg[1] ? 12 : 1)));
	endtask
	task automatic tally_and_finish();
		$display("checks %0d errors %0d", total_checks, error_cnt);
		if (error_cnt == 0 && total_checks > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask
	initial begin
		#(20 * 3000);
		error_cnt++;
		tally_and_finish();
	end
	initial begin
		{rstn, conversion_done, clear_done, irq_enable, clear_irq, wait_start} = 6'h00;
		{visible_channel, infrared_channel, low_threshold} = 48'h0;
		high_threshold = 16'h1000;
		persistence = 4'h1;
		wait_period_field = 8'h00;
		repeat (20) @(negedge core_clk);
		rstn = 1'b1;
		check(gain_select_field, 2'h0);
		foreach (rows[i]) begin
			i_host_model.write_reg(rows[i].a, rows[i].w);
			rd_chk(rows[i].a, rows[i].e);
			if (rows[i].a == OFS_GAIN_CTRL) check(gain_select_field, rows[i].w[1:0]);
		end
		wait_len(8'h02, 8'hFF);
		wait_len(8'h00, 8'hFE);
		conv(16'h1234, 16'hABCD);
		rd_chk(OFS_FLAGS, 8'h01);
		irq_enable = 1'b1;
		conv(16'h1234, 16'hABCD);
		check(light_irq_out, 1'b1);
		rd_chk(OFS_FLAGS, 8'h11);
		irq_enable = 1'b0;
		pulse(clear_irq);
		rd_chk(OFS_FLAGS, 8'h01);
		pulse(clear_done);
		rd_chk(OFS_FLAGS, 8'h00);
		rd_chk(OFS_VIS_LOW, 8'h34);
		conv(16'h5678, 16'h9999);
		rd_chk(OFS_VIS_HIGH, 8'h12);
		rd_chk(OFS_IR_LOW, 8'h99);
		conv(16'h4321, 16'h8765);
		rd_chk(OFS_VIS_LOW, 8'h21);
		rd_chk(OFS_IR_HIGH, 8'h99);
		rd_chk(OFS_VIS_HIGH, 8'h43);
		i_host_model.read_pair(OFS_IR_LOW, pd);
		check(pd, 16'h8765);
		i_host_model.read_pair(OFS_VIS_LOW, pd);
		check(pd, 16'h4321);
		// persistence of two, below low threshold
		persistence = 4'h2;
		low_threshold = 16'h0100;
		irq_enable = 1'b1;
		conv(16'h0800, 16'h0000);
		conv(16'h0050, 16'h0000);
		check(light_irq_out, 1'b0);
		conv(16'h0050, 16'h0000);
		check(light_irq_out, 1'b1);
		// mid-run reset clears registers
		i_host_model.write_reg(OFS_WAIT_EXT_CFG, 8'h02);
		rstn = 1'b0;
		@(negedge core_clk);
		rstn = 1'b1;
		check(light_irq_out, 1'b0);
		check(gain_select_field, 2'h0);
		rd_chk(OFS_WAIT_EXT_CFG, 8'h00);
		rd_chk(OFS_FLAGS, 8'h00);
		rd_chk(OFS_VIS_LOW, 8'h00);
		tally_and_finish();
	end
endmodule
